// file: logic/sgc_pkg.sv
// Constants shared by the switch global control block and its helpers.
// Assumes one 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package sgc_pkg;

  // Printed register indices; the byte address is four times the index.
  localparam logic [7:0] CTRL_ZERO_IDX = 8'h02;
  localparam logic [7:0] CTRL_ONE_IDX  = 8'h03;
  localparam logic [7:0] CTRL_ZERO_ADDR = 8'(CTRL_ZERO_IDX * 4);
  localparam logic [7:0] CTRL_ONE_ADDR  = 8'(CTRL_ONE_IDX * 4);

  // Field positions of the first control register.
  localparam int Z_STATIC_FLUSH  = 4;
  localparam int Z_INTEROP_DROP  = 1;
  localparam int Z_LINK_AGE      = 0;
  localparam logic [7:0] Z_FIXED_ONES = 8'h0c;
  localparam logic [7:0] Z_WRITE_MASK = 8'h03;

  // Field positions of the second control register.
  localparam int O_JUMBO_2K      = 6;
  localparam int O_TX_FC_OFF     = 5;
  localparam int O_RX_FC_OFF     = 4;
  localparam int O_LEN_CHECK     = 3;
  localparam int O_AGE_EN        = 2;
  localparam int O_FAST_AGE      = 1;
  localparam int O_AGGR_BACKOFF  = 0;
  localparam logic [7:0] O_WRITE_MASK = 8'h7f;
  // Reset value before the strap is folded into bits 5 and 4.
  localparam logic [7:0] O_RESET = 8'h04;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing.
  localparam longint unsigned CLK_HZ       = 125_000_000;
  localparam longint unsigned AGE_NORMAL_S = 300;
  localparam longint unsigned AGE_FAST_US  = 800;
  localparam int AGE_CNT_W = 36;
  localparam logic [35:0] AGE_NORMAL_CYC = 36'(AGE_NORMAL_S * CLK_HZ);
  // Longest time, so the division rounds down.
  localparam logic [35:0] AGE_FAST_CYC = 36'((AGE_FAST_US * CLK_HZ) / 1_000_000);

  // Frame checks.
  localparam logic [15:0] PAUSE_TYPE       = 16'h8808;
  localparam logic [47:0] PAUSE_DA         = 48'h0180c2000001;
  localparam logic [11:0] LEN_FIELD_LIMIT  = 12'h5dc;
  localparam logic [11:0] MAX_LEN_STD      = 12'h5f2;
  localparam logic [11:0] MAX_LEN_2K       = 12'h800;

  // Static address table.
  localparam int PORTS       = 4;
  localparam int ST_ENTRIES  = 32;
  localparam int ST_IDX_W    = 5;

endpackage

`default_nettype wire

// file: logic/sgc_age_timer.sv
// Address-table age timer with normal and fast periods.
// Assumes link-loss requests arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sgc_age_timer
  import sgc_pkg::*;
#(
  parameter logic [35:0] NORMAL_CYC = AGE_NORMAL_CYC,
  parameter logic [35:0] FAST_CYC   = AGE_FAST_CYC
)
(
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control.
  input  wire logic age_en_i,
  input  wire logic fast_i,
  input  wire logic link_loss_i,
  // Events.
  output logic      age_tick_o,
  output logic      age_all_o
);
  import sgc_pkg::*;

  logic [35:0] cnt_reg;
  logic        once_reg;
  logic [35:0] period;
  logic        done;

  assign period = (fast_i || once_reg) ? FAST_CYC : NORMAL_CYC;
  assign done   = age_en_i && (cnt_reg >= period - 36'h1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !age_en_i || done)
      cnt_reg <= 36'h0;
    else
      cnt_reg <= cnt_reg + 36'h1;
  end

  // One fast cycle per link loss, then back to the normal period.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !age_en_i)
      once_reg <= 1'b0;
    else if (link_loss_i)
      once_reg <= 1'b1;
    else if (done)
      once_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      age_tick_o <= 1'b0;
      age_all_o  <= 1'b0;
    end
    else
    begin
      age_tick_o <= done;
      age_all_o  <= done && once_reg && !link_loss_i;
    end
  end

endmodule

`default_nettype wire

// file: logic/sgc_frame_filter.sv
// Per-frame drop decision from the global frame policy bits.
// Assumes a frame descriptor is presented for one cycle with its valid.
`timescale 1ns/1ps
`default_nettype none

module sgc_frame_filter
  import sgc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Policy.
  input  wire logic        interop_pause_drop_mode_i,
  input  wire logic        len_check_i,
  input  wire logic        jumbo_2k_i,
  // Frame descriptor.
  input  wire logic        frm_valid_i,
  input  wire logic [15:0] frm_type_len_i,
  input  wire logic [47:0] frm_dst_mac_i,
  input  wire logic        frm_is_flow_ctrl_i,
  input  wire logic [11:0] frm_len_i,
  input  wire logic [11:0] frm_payload_len_i,
  // Verdict.
  output logic             verdict_valid_o,
  output logic             verdict_drop_o
);
  import sgc_pkg::*;

  logic pause_drop;
  logic len_drop;
  logic size_drop;

  always_comb
  begin
    if (interop_pause_drop_mode_i)
      pause_drop = (frm_type_len_i == PAUSE_TYPE) || (frm_dst_mac_i == PAUSE_DA);
    else
      pause_drop = frm_is_flow_ctrl_i;
    len_drop  = len_check_i && (frm_type_len_i < 16'(LEN_FIELD_LIMIT))
                && (frm_type_len_i != 16'(frm_payload_len_i));
    size_drop = frm_len_i > (jumbo_2k_i ? MAX_LEN_2K : MAX_LEN_STD);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      verdict_valid_o <= 1'b0;
      verdict_drop_o  <= 1'b0;
    end
    else
    begin
      verdict_valid_o <= frm_valid_i;
      verdict_drop_o  <= frm_valid_i && (pause_drop || len_drop || size_drop);
    end
  end

endmodule

`default_nettype wire

// file: logic/sgc_global_ctrl.sv
// Global control registers of a four-port switch, with static flush and aging.
// Assumes an AXI4-Lite master, same-clock switch core signals and pin-level
// link status and strap inputs.
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter logic [35:0] AGE_NORMAL_CYCLES = sgc_pkg::AGE_NORMAL_CYC,
  parameter logic [35:0] AGE_FAST_CYCLES   = sgc_pkg::AGE_FAST_CYC
)
(
  // Clock and reset.
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]                 s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  // AXI4-Lite read.
  input  wire logic [7:0]                 s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  // Pins.
  input  wire logic [sgc_pkg::PORTS-1:0]  link_up_i,
  input  wire logic                       fc_disable_strap_i,
  // Autonegotiation results per port.
  input  wire logic [sgc_pkg::PORTS-1:0]  an_tx_pause_i,
  input  wire logic [sgc_pkg::PORTS-1:0]  an_rx_pause_i,
  // Static address table walk.
  output logic [sgc_pkg::ST_IDX_W-1:0]    st_idx_o,
  input  wire logic [sgc_pkg::PORTS-1:0]  st_fwd_ports_i,
  input  wire logic                       st_valid_i,
  input  wire logic                       st_unicast_i,
  input  wire logic [sgc_pkg::PORTS-1:0]  port_learn_dis_i,
  output logic                            st_invalidate_o,
  // Frame descriptor and verdict.
  input  wire logic                       frm_valid_i,
  input  wire logic [15:0]                frm_type_len_i,
  input  wire logic [47:0]                frm_dst_mac_i,
  input  wire logic                       frm_is_flow_ctrl_i,
  input  wire logic [11:0]                frm_len_i,
  input  wire logic [11:0]                frm_payload_len_i,
  output logic                            verdict_valid_o,
  output logic                            verdict_drop_o,
  // Core controls.
  output logic [sgc_pkg::PORTS-1:0]       tx_pause_en_o,
  output logic [sgc_pkg::PORTS-1:0]       rx_pause_en_o,
  output logic                            aggr_backoff_o,
  output logic                            age_tick_o,
  output logic                            age_all_o
);
  import sgc_pkg::*;

  typedef enum logic [2:0]
  {
    FL_IDLE = 3'b001,
    FL_WALK = 3'b010,
    FL_LAST = 3'b100
  } sgc_flush_e;

  // True when exactly one bit of a port vector is set.
  function automatic logic sgc_one_port(input logic [PORTS-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < PORTS; i++)
      n = n + {2'h0, v[i]};
    return n == 3'h1;
  endfunction

  // Byte address to register select.
  function automatic logic [1:0] sgc_decode(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a == CTRL_ZERO_ADDR)
      s = 2'h1;
    else if (a == CTRL_ONE_ADDR)
      s = 2'h2;
    return s;
  endfunction

  logic [7:0]          zero_reg;
  logic [7:0]          one_reg;
  logic                strap_load_reg;
  logic [PORTS-1:0]    link_s1_reg;
  logic [PORTS-1:0]    link_s2_reg;
  logic [PORTS-1:0]    link_prev_reg;
  logic                strap_s1_reg;
  logic                strap_s2_reg;
  logic                link_loss_reg;
  sgc_flush_e          fl_reg;
  logic [ST_IDX_W-1:0] idx_reg;
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [7:0]          awaddr_reg;
  logic [7:0]          wdata_reg;
  logic                wstrb0_reg;
  logic                wr_fire;
  logic [1:0]          wr_sel;
  logic                flush_req;
  logic                flush_busy;
  logic                st_match;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge clk_sys_i)
  begin
    link_s1_reg  <= link_up_i;
    link_s2_reg  <= link_s1_reg;
    strap_s1_reg <= fc_disable_strap_i;
    strap_s2_reg <= strap_s1_reg;
  end

  // A falling link on any port is one link-loss event.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      link_prev_reg <= '0;
      link_loss_reg <= 1'b0;
    end
    else
    begin
      link_prev_reg <= link_s2_reg;
      link_loss_reg <= zero_reg[Z_LINK_AGE] && |(link_prev_reg & ~link_s2_reg);
    end
  end

  // Write channel: address and data are taken in either order.
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign wr_sel  = sgc_decode(awaddr_reg);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr_i;
    end
    else if (wr_fire)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 8'h0;
      wstrb0_reg <= 1'b0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata_i[7:0];
      wstrb0_reg <= s_axi_wstrb_i[0];
    end
    else if (wr_fire)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end
    else
    begin
      s_axi_awready_o <= !aw_held_reg && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o  <= !w_held_reg && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_sel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // First control register; bit 4 is the live flush state, not stored here.
  assign flush_req = wr_fire && wstrb0_reg && (wr_sel == 2'h1) && wdata_reg[Z_STATIC_FLUSH];

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      zero_reg <= Z_FIXED_ONES;
    else if (wr_fire && wstrb0_reg && wr_sel == 2'h1)
      zero_reg <= (wdata_reg & Z_WRITE_MASK) | Z_FIXED_ONES;
  end

  // The strap is caught one cycle after reset, through its synchroniser.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      strap_load_reg <= 1'b1;
    else
      strap_load_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      one_reg <= O_RESET;
    else if (wr_fire && wstrb0_reg && wr_sel == 2'h2)
      one_reg <= wdata_reg & O_WRITE_MASK;
    else if (strap_load_reg)
    begin
      one_reg[O_TX_FC_OFF] <= strap_s2_reg;
      one_reg[O_RX_FC_OFF] <= strap_s2_reg;
    end
  end

  // Flush walk: one static entry per cycle, index presented from a flip-flop.
  assign flush_busy = (fl_reg != FL_IDLE);
  assign st_match   = st_valid_i && st_unicast_i && sgc_one_port(st_fwd_ports_i)
                      && |(st_fwd_ports_i & port_learn_dis_i);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      fl_reg  <= FL_IDLE;
      idx_reg <= '0;
    end
    else
    begin
      unique case (fl_reg)
        FL_IDLE:
        begin
          idx_reg <= '0;
          if (flush_req)
            fl_reg <= FL_WALK;
        end
        FL_WALK:
        begin
          idx_reg <= idx_reg + ST_IDX_W'(1);
          if (idx_reg == ST_IDX_W'(ST_ENTRIES - 2))
            fl_reg <= FL_LAST;
        end
        FL_LAST:
        begin
          idx_reg <= '0;
          // A new request landing on the last entry restarts the walk.
          fl_reg <= flush_req ? FL_WALK : FL_IDLE;
        end
        default:
          fl_reg <= FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_idx_o        <= '0;
      st_invalidate_o <= 1'b0;
    end
    else
    begin
      st_idx_o        <= idx_reg;
      st_invalidate_o <= (fl_reg != FL_IDLE) && st_match;
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= RESP_OKAY;
        unique case (sgc_decode(s_axi_araddr_i))
          2'h1:
            s_axi_rdata_o <= {24'h0, zero_reg[7:5], flush_busy, zero_reg[3:0]};
          2'h2:
            s_axi_rdata_o <= {24'h0, one_reg};
          default:
          begin
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // Pause enables and back-off are registered for clean timing to the ports.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tx_pause_en_o  <= '0;
      rx_pause_en_o  <= '0;
      aggr_backoff_o <= 1'b0;
    end
    else
    begin
      tx_pause_en_o  <= one_reg[O_TX_FC_OFF] ? '0 : an_tx_pause_i;
      rx_pause_en_o  <= one_reg[O_RX_FC_OFF] ? '0 : an_rx_pause_i;
      aggr_backoff_o <= one_reg[O_AGGR_BACKOFF];
    end
  end

  sgc_age_timer #(
    .NORMAL_CYC (AGE_NORMAL_CYCLES),
    .FAST_CYC   (AGE_FAST_CYCLES)
  ) u_age (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .age_en_i    (one_reg[O_AGE_EN]),
    .fast_i      (one_reg[O_FAST_AGE]),
    .link_loss_i (link_loss_reg),
    .age_tick_o  (age_tick_o),
    .age_all_o   (age_all_o)
  );

  sgc_frame_filter u_filter (
    .clk_sys_i                 (clk_sys_i),
    .rst_i                     (rst_i),
    .interop_pause_drop_mode_i (zero_reg[Z_INTEROP_DROP]),
    .len_check_i               (one_reg[O_LEN_CHECK]),
    .jumbo_2k_i                (one_reg[O_JUMBO_2K]),
    .frm_valid_i               (frm_valid_i),
    .frm_type_len_i            (frm_type_len_i),
    .frm_dst_mac_i             (frm_dst_mac_i),
    .frm_is_flow_ctrl_i        (frm_is_flow_ctrl_i),
    .frm_len_i                 (frm_len_i),
    .frm_payload_len_i         (frm_payload_len_i),
    .verdict_valid_o           (verdict_valid_o),
    .verdict_drop_o            (verdict_drop_o)
  );

endmodule

`default_nettype wire

// file: test/sgc_global_ctrl_chk.sv
// Port-level checker for the switch global control block.
// Assumes it is bound to sgc_global_ctrl and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl_chk
  import sgc_pkg::*;
(
  // Clock and reset.
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  // Bus answers.
  input  wire logic                      s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [1:0]                s_axi_bresp_o,
  input  wire logic                      s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  input  wire logic [31:0]               s_axi_rdata_o,
  // Frames.
  input  wire logic                      frm_valid_i,
  input  wire logic [15:0]               frm_type_len_i,
  input  wire logic [47:0]               frm_dst_mac_i,
  input  wire logic                      frm_is_flow_ctrl_i,
  input  wire logic                      verdict_valid_o,
  input  wire logic                      verdict_drop_o,
  // Pause and table.
  input  wire logic [sgc_pkg::PORTS-1:0] an_tx_pause_i,
  input  wire logic [sgc_pkg::PORTS-1:0] an_rx_pause_i,
  input  wire logic [sgc_pkg::PORTS-1:0] tx_pause_en_o,
  input  wire logic [sgc_pkg::PORTS-1:0] rx_pause_en_o,
  input  wire logic                      st_invalidate_o,
  input  wire logic                      st_valid_i,
  input  wire logic                      st_unicast_i,
  input  wire logic [sgc_pkg::PORTS-1:0] st_fwd_ports_i,
  input  wire logic [sgc_pkg::PORTS-1:0] port_learn_dis_i,
  input  wire logic                      age_tick_o,
  input  wire logic                      age_all_o
);
  logic entry_ok_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // The table input describes the entry that the walk shows one cycle later.
  always_ff @(posedge clk_sys_i)
  begin
    entry_ok_reg <= st_valid_i && st_unicast_i && $onehot(st_fwd_ports_i) && |(st_fwd_ports_i & port_learn_dis_i);
  end

  a_verdict_latency: assert property (frm_valid_i |=> verdict_valid_o)
    else $error("verdict missing after frame");
  a_verdict_quiet: assert property (!frm_valid_i |=> !verdict_valid_o)
    else $error("verdict without frame");
  a_pause_dropped: assert property (frm_valid_i && frm_is_flow_ctrl_i && frm_type_len_i == PAUSE_TYPE
    && frm_dst_mac_i == PAUSE_DA |=> verdict_drop_o) else $error("pause frame not dropped");
  a_tx_pause_gate: assert property ((tx_pause_en_o & ~$past(an_tx_pause_i)) == '0)
    else $error("tx pause on without negotiation");
  a_rx_pause_gate: assert property ((rx_pause_en_o & ~$past(an_rx_pause_i)) == '0)
    else $error("rx pause on without negotiation");
  a_inval_matched: assert property (st_invalidate_o |-> entry_ok_reg)
    else $error("unmatched entry invalidated");
  a_all_with_tick: assert property (age_all_o |-> age_tick_o)
    else $error("age all outside an age cycle end");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");

  c_invalidate: cover property (st_invalidate_o);
  c_age_all: cover property (age_all_o);
  c_drop: cover property (verdict_valid_o && verdict_drop_o);
endmodule

bind sgc_global_ctrl sgc_global_ctrl_chk i_chk (.clk_sys_i, .rst_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .frm_valid_i, .frm_type_len_i, .frm_dst_mac_i,
  .frm_is_flow_ctrl_i, .verdict_valid_o, .verdict_drop_o, .an_tx_pause_i, .an_rx_pause_i, .tx_pause_en_o,
  .rx_pause_en_o, .st_invalidate_o, .st_valid_i, .st_unicast_i, .st_fwd_ports_i, .port_learn_dis_i,
  .age_tick_o, .age_all_o);

`default_nettype wire

// file: test/sgc_global_ctrl_tb.sv
// Self-checking bench for the switch global control block.
// Assumes the checker is bound separately; short age periods keep the run brief.
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl_tb;
  import sgc_pkg::*;
  localparam logic [35:0] NORM_CYC = 36'd200;
  localparam logic [35:0] FAST_CYC = 36'd20;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, fc_disable_strap_i = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, inv_mask = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'h0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [3:0]  link_up_i = 4'hf, an_tx_pause_i = 4'hf, an_rx_pause_i = 4'h5, port_learn_dis_i = 4'h2;
  logic [3:0]  st_fwd_ports_i, tx_pause_en_o, rx_pause_en_o;
  logic        st_valid_i, st_unicast_i, st_invalidate_o;
  logic [4:0]  st_idx_o, ent_idx;
  logic        frm_valid_i = 1'b0, frm_is_flow_ctrl_i = 1'b0;
  logic [15:0] frm_type_len_i = 16'h0;
  logic [47:0] frm_dst_mac_i = 48'h0;
  logic [11:0] frm_len_i = 12'h0, frm_payload_len_i = 12'h0;
  logic        verdict_valid_o, verdict_drop_o, aggr_backoff_o, age_tick_o, age_all_o;
  int          error_cnt = 0, samples_checked = 0;

  sgc_global_ctrl #(.AGE_NORMAL_CYCLES(NORM_CYC), .AGE_FAST_CYCLES(FAST_CYC)) i_dut (.*);

  always #4 clk_sys_i = ~clk_sys_i;

  // Entries 5 and 9 match; 6, 7 and 10 each fail one test.
  assign ent_idx = st_idx_o + 5'h01;
  assign st_valid_i = ent_idx inside {5'd5, 5'd6, 5'd7, 5'd9, 5'd10};
  assign st_unicast_i = (ent_idx != 5'd7);
  assign st_fwd_ports_i = (ent_idx == 5'd6) ? 4'h3 : (ent_idx == 5'd10) ? 4'h4 : 4'h2;

  always @(posedge clk_sys_i)
    if (st_invalidate_o === 1'b1) inv_mask[st_idx_o] <= 1'b1;

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_up(input string name);
    chk(name, 32'h1, 32'h0);
    wrap_up();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    bit done;
    done = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1)
      begin
        r = s_axi_bresp_o;
        done = 1'b1;
      end
    end
    s_axi_bready_i <= 1'b0;
    if (!done) give_up("write timeout");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit done;
    done = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1)
      begin
        chk("rdata", exp, s_axi_rdata_o);
        chk("rresp", 32'(er), 32'(s_axi_rresp_o));
        done = 1'b1;
      end
    end
    s_axi_rready_i <= 1'b0;
    if (!done) give_up("read timeout");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'h1, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic frame(input logic [15:0] tl, input logic [47:0] da, input logic fc, input logic [11:0] len,
                       input logic [11:0] pay, input logic drop);
    frm_type_len_i <= tl;
    frm_dst_mac_i <= da;
    frm_is_flow_ctrl_i <= fc;
    frm_len_i <= len;
    frm_payload_len_i <= pay;
    frm_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    frm_valid_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("verdict_valid", 32'h1, 32'(verdict_valid_o));
    chk("verdict_drop", 32'(drop), 32'(verdict_drop_o));
  endtask

  task automatic wait_tick(output int n, input bit all = 1'b0);
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while ((all ? age_all_o : age_tick_o) !== 1'b1 && n < 400);
    if (n == 400) give_up("age tick timeout");
  endtask

  task automatic t_reset_map();
    logic [1:0] r;
    rd(CTRL_ZERO_ADDR, 32'h0c, RESP_OKAY);
    rd(CTRL_ONE_ADDR, 32'h34, RESP_OKAY);
    chk("tx_pause", 32'h0, 32'(tx_pause_en_o));
    chk("rx_pause", 32'h0, 32'(rx_pause_en_o));
    rd(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 8'hff, 4'hf, r);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
  endtask

  task automatic t_fields();
    logic [1:0] r;
    wr(CTRL_ONE_ADDR, 8'h10);
    repeat (2) @(posedge clk_sys_i);
    chk("tx_pause", 32'hf, 32'(tx_pause_en_o));
    chk("rx_pause", 32'h0, 32'(rx_pause_en_o));
    an_tx_pause_i <= 4'h9;
    wr(CTRL_ONE_ADDR, 8'h20);
    repeat (2) @(posedge clk_sys_i);
    chk("tx_pause", 32'h0, 32'(tx_pause_en_o));
    chk("rx_pause", 32'h5, 32'(rx_pause_en_o));
    wr(CTRL_ONE_ADDR, 8'hff);
    rd(CTRL_ONE_ADDR, 32'h7f, RESP_OKAY);
    chk("aggr_backoff", 32'h1, 32'(aggr_backoff_o));
    axi_wr(CTRL_ONE_ADDR, 8'h00, 4'he, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    rd(CTRL_ONE_ADDR, 32'h7f, RESP_OKAY);
    wr(CTRL_ZERO_ADDR, 8'hef);
    rd(CTRL_ZERO_ADDR, 32'h0f, RESP_OKAY);
  endtask

  task automatic t_frames();
    frame(PAUSE_TYPE, 48'h0, 1'b0, 12'd64, 12'd46, 1'b1);
    frame(16'h0800, PAUSE_DA, 1'b0, 12'd64, 12'd46, 1'b1);
    frame(16'h0800, 48'h0200_0000_0005, 1'b1, 12'd64, 12'd46, 1'b0);
    frame(16'h0800, 48'h0200_0000_0005, 1'b0, 12'd2000, 12'd46, 1'b0);
    frame(16'd100, 48'h0200_0000_0005, 1'b0, 12'd118, 12'd50, 1'b1);
    frame(16'd100, 48'h0200_0000_0005, 1'b0, 12'd118, 12'd100, 1'b0);
    frame(16'd1500, 48'h0200_0000_0005, 1'b0, 12'd118, 12'd50, 1'b0);
    wr(CTRL_ZERO_ADDR, 8'h00);
    wr(CTRL_ONE_ADDR, 8'h04);
    frame(PAUSE_TYPE, PAUSE_DA, 1'b0, 12'd64, 12'd46, 1'b0);
    frame(PAUSE_TYPE, PAUSE_DA, 1'b1, 12'd64, 12'd46, 1'b1);
    frame(16'h0800, 48'h0200_0000_0005, 1'b0, 12'd2000, 12'd46, 1'b1);
    frame(16'd100, 48'h0200_0000_0005, 1'b0, 12'd1522, 12'd50, 1'b0);
  endtask

  task automatic t_flush();
    wr(CTRL_ZERO_ADDR, 8'h10);
    rd(CTRL_ZERO_ADDR, 32'h1c, RESP_OKAY);
    repeat (40) @(posedge clk_sys_i);
    rd(CTRL_ZERO_ADDR, 32'h0c, RESP_OKAY);
    chk("invalidated", 32'h220, inv_mask);
  endtask

  task automatic t_aging();
    int n, ticks;
    wait_tick(n);
    wait_tick(n);
    chk("normal period", 32'd200, 32'(n));
    wr(CTRL_ONE_ADDR, 8'h06);
    wait_tick(n);
    wait_tick(n);
    chk("fast period", 32'd20, 32'(n));
    wr(CTRL_ONE_ADDR, 8'h00);
    ticks = 0;
    repeat (450) @(posedge clk_sys_i) if (age_tick_o === 1'b1) ticks++;
    chk("ticks when off", 32'h0, 32'(ticks));
    wr(CTRL_ONE_ADDR, 8'h04);
    wr(CTRL_ZERO_ADDR, 8'h01);
    wait_tick(n);
    link_up_i <= 4'hb;
    wait_tick(n, 1'b1);
    chk("fast cycle", 32'h1, 32'(n < 30));
    chk("age all", 32'h1, 32'(age_all_o));
    wait_tick(n);
    chk("period after fast", 32'd200, 32'(n));
    chk("age all again", 32'h0, 32'(age_all_o));
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset_map();
    t_fields();
    t_frames();
    t_flush();
    t_aging();
    wrap_up();
  end
endmodule

`default_nettype wire
